// >>> logic/ocr_osc_ctrl.sv
// Oscillator control, clock divider and RC tune registers on AXI4-Lite
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
module ocr_osc_ctrl
  import ocr_pkg::*;
#(
  parameter logic [2:0] RESET_SOURCE = 3'h7
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        monitor_switch_cfg,
  input  wire logic        io_lock_one_way_cfg,
  input  wire logic        pll_locked_in,
  input  wire logic        clock_fail_in,
  input  wire logic        switch_ready_in,
  input  wire logic        irq_event,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic        tune_in_band,
  input  wire logic        tune_beyond_range,
  input  wire logic        tune_step,
  input  wire logic        tune_up,
  output logic             primary_osc_run,
  output logic             secondary_osc_run,
  output logic             pll_run,
  output logic [2:0]       source_sel_out,
  output logic             io_lock_out,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             rc_clk_en,
  output logic [1:0]       sys_postscale_out,
  output logic             selftune_active,
  output logic             selftune_ref_out,
  output logic [5:0]       rc_trim_out,
  output logic             lock_irq,
  output logic             range_irq
);

  // Pin-level inputs from other clock domains: two-stage sync
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {pll_locked_in, clock_fail_in, switch_ready_in,
                    tune_in_band, tune_beyond_range, tune_step, tune_up};
      sync2_reg <= sync1_reg;
    end
  end
  logic pll_lk_s, cfail_s, sw_rdy_s, in_band_s, beyond_s, step_s, up_s;
  assign {pll_lk_s, cfail_s, sw_rdy_s, in_band_s, beyond_s, step_s, up_s} =
    sync2_reg;

  logic step_d_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      step_d_reg <= 1'b0;
    else
      step_d_reg <= step_s;
  end

  // Register state
  logic [2:0] csel_reg, nsel_reg;
  logic       sel_lock_reg, io_lock_reg, plock_reg, cfail_reg;
  logic       psleep_reg, secondary_osc_reg, swreq_reg;
  logic       roi_reg, doze_enable_reg, pllon_reg;
  logic [2:0] doze_reg, rcps_reg;
  logic [1:0] sysps_reg;
  logic       selftune_enable_reg, idlestop_reg, refsel_reg, lpol_reg, rpol_reg;
  logic       locked_reg, range_reg;
  logic [5:0] trim_reg;
  logic       key1_reg, unlocked_reg;
  logic       strap_done_reg;
  ocr_sw_t    sw_state_reg;

  // AXI write channel
  logic       aw_hold_reg, w_hold_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       wr_fire;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr_reg   <= '0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
        aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_reg   <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
    end
    else
    begin
      s_axi_wready <= !w_hold_reg && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
        w_hold_reg <= 1'b0;
    end
  end

  logic wr_known;
  assign wr_known = aw_addr_reg == OCR_OFS_OSC_CTRL ||
                    aw_addr_reg == OCR_OFS_CLK_DIV ||
                    aw_addr_reg == OCR_OFS_RC_TUNE ||
                    aw_addr_reg == OCR_OFS_UNLOCK;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= OCR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? OCR_RESP_OKAY : OCR_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Write decode per register with byte lanes
  logic wr_osc_lo, wr_osc_hi, wr_div_lo, wr_div_hi, wr_tun_lo, wr_tun_hi;
  logic wr_key;
  assign wr_osc_lo = wr_fire && aw_addr_reg == OCR_OFS_OSC_CTRL && w_strb_reg[0];
  assign wr_osc_hi = wr_fire && aw_addr_reg == OCR_OFS_OSC_CTRL && w_strb_reg[1];
  assign wr_div_lo = wr_fire && aw_addr_reg == OCR_OFS_CLK_DIV && w_strb_reg[0];
  assign wr_div_hi = wr_fire && aw_addr_reg == OCR_OFS_CLK_DIV && w_strb_reg[1];
  assign wr_tun_lo = wr_fire && aw_addr_reg == OCR_OFS_RC_TUNE && w_strb_reg[0];
  assign wr_tun_hi = wr_fire && aw_addr_reg == OCR_OFS_RC_TUNE && w_strb_reg[1];
  assign wr_key    = wr_fire && aw_addr_reg == OCR_OFS_UNLOCK && w_strb_reg[0];

  // Unlock: key1 then key2 arms one following control write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key1_reg     <= 1'b0;
      unlocked_reg <= 1'b0;
    end
    else if (wr_key)
    begin
      key1_reg     <= w_data_reg[7:0] == OCR_KEY1;
      unlocked_reg <= key1_reg && w_data_reg[7:0] == OCR_KEY2;
    end
    else if (wr_fire)
    begin
      key1_reg     <= 1'b0;
      unlocked_reg <= 1'b0;
    end
  end

  // Switches allowed: monitor off, or lock bit clear
  logic switch_allowed;
  assign switch_allowed = !monitor_switch_cfg || !sel_lock_reg;

  // Redundancy test sees a selection written in the same word
  logic [2:0] nsel_cmp;
  assign nsel_cmp = (wr_osc_hi && unlocked_reg && switch_allowed) ?
                    w_data_reg[OCR_NSEL_LSB +: 3] : nsel_reg;

  // Strap capture after reset release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      strap_done_reg <= 1'b0;
    else
      strap_done_reg <= 1'b1;
  end

  // Selection and switch sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      csel_reg     <= 3'h7;
      nsel_reg     <= 3'h7;
      swreq_reg    <= 1'b0;
      sw_state_reg <= OCR_SW_IDLE;
    end
    else
    begin
      if (!strap_done_reg)
      begin
        csel_reg <= RESET_SOURCE;
        nsel_reg <= RESET_SOURCE;
      end
      if (wr_osc_hi && unlocked_reg && switch_allowed)
        nsel_reg <= w_data_reg[OCR_NSEL_LSB +: 3];
      unique case (sw_state_reg)
        OCR_SW_IDLE:
        begin
          if (wr_osc_lo && unlocked_reg && switch_allowed &&
              w_data_reg[OCR_SWREQ_BIT])
          begin
            swreq_reg    <= 1'b1;
            sw_state_reg <= (nsel_cmp == csel_reg) ? OCR_SW_DONE
                                                   : OCR_SW_WAIT;
          end
        end
        OCR_SW_WAIT:
          if (sw_rdy_s)
            sw_state_reg <= OCR_SW_DONE;
        OCR_SW_DONE:
        begin
          swreq_reg    <= 1'b0;
          csel_reg     <= nsel_reg;
          sw_state_reg <= OCR_SW_IDLE;
        end
      endcase
    end
  end

  logic pll_mode;
  assign pll_mode = csel_reg == OCR_SEL_PRI_PLL || csel_reg == OCR_SEL_FRC_PLL;

  // Low-byte status and control of oscillator control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_lock_reg <= 1'b0;
      io_lock_reg  <= 1'b0;
      plock_reg    <= 1'b0;
      cfail_reg    <= 1'b0;
      psleep_reg   <= 1'b0;
      secondary_osc_reg     <= 1'b0;
    end
    else
    begin
      if (wr_osc_lo && unlocked_reg)
      begin
        // Lock bit is set-only
        if (w_data_reg[OCR_SELLOCK_BIT])
          sel_lock_reg <= 1'b1;
        if (!(io_lock_one_way_cfg && io_lock_reg))
          io_lock_reg <= w_data_reg[OCR_IO_LOCK_A_BIT];
        psleep_reg <= w_data_reg[OCR_PSLEEP_BIT];
        secondary_osc_reg   <= w_data_reg[OCR_SECONDARY_OSC_ENABLE_BIT];
      end
      if (cfail_s)
        cfail_reg <= 1'b1;
      else if (wr_osc_lo && !w_data_reg[OCR_CFAIL_BIT])
        cfail_reg <= 1'b0;
      if (sw_state_reg != OCR_SW_IDLE || !pll_mode)
        plock_reg <= 1'b0;
      else
        plock_reg <= pll_lk_s;
    end
  end

  // Clock divider register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      roi_reg   <= 1'b0;
      doze_reg  <= OCR_DOZE_RST;
      doze_enable_reg <= 1'b0;
      rcps_reg  <= OCR_RCPS_RST;
      sysps_reg <= OCR_SYSPS_RST;
      pllon_reg <= 1'b0;
    end
    else
    begin
      if (wr_div_hi)
      begin
        roi_reg   <= w_data_reg[OCR_ROI_BIT];
        doze_reg  <= w_data_reg[OCR_DOZE_LSB +: 3];
        doze_enable_reg <= w_data_reg[OCR_DOZE_ENABLE_BIT];
        rcps_reg  <= w_data_reg[OCR_RCPS_LSB +: 3];
      end
      if (roi_reg && irq_event)
        doze_enable_reg <= 1'b0;
      if (wr_div_lo)
      begin
        sysps_reg <= w_data_reg[OCR_SYSPS_LSB +: 2];
        pllon_reg <= w_data_reg[OCR_PLLON_BIT];
      end
    end
  end

  // Tune control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      selftune_enable_reg     <= 1'b0;
      idlestop_reg <= 1'b0;
      refsel_reg   <= 1'b0;
      lpol_reg     <= 1'b0;
      rpol_reg     <= 1'b0;
      locked_reg   <= 1'b0;
      range_reg    <= 1'b0;
      trim_reg     <= '0;
    end
    else
    begin
      if (wr_tun_hi)
      begin
        selftune_enable_reg     <= w_data_reg[OCR_SELFTUNE_ENABLE_BIT];
        idlestop_reg <= w_data_reg[OCR_IDLESTOP_BIT];
        refsel_reg   <= w_data_reg[OCR_REFSEL_BIT];
        lpol_reg     <= w_data_reg[OCR_LPOL_BIT];
        rpol_reg     <= w_data_reg[OCR_RPOL_BIT];
      end
      locked_reg <= selftune_enable_reg && in_band_s;
      range_reg  <= selftune_enable_reg && beyond_s;
      if (wr_tun_lo && !selftune_enable_reg)
        trim_reg <= w_data_reg[OCR_TRIM_LSB +: 6];
      // no step when out of range
      else if (selftune_enable_reg && step_s && !step_d_reg && !beyond_s &&
               !(idlestop_reg && idle_mode))
        trim_reg <= up_s ? ((trim_reg == 6'h1F) ? trim_reg
                                                 : trim_reg + 6'h01)
                         : ((trim_reg == 6'h20) ? trim_reg
                                                 : trim_reg - 6'h01);
    end
  end

  // Tune interrupts: pulse on entering the chosen state
  logic lock_match_reg, range_match_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_match_reg  <= 1'b0;
      range_match_reg <= 1'b0;
      lock_irq        <= 1'b0;
      range_irq       <= 1'b0;
    end
    else
    begin
      lock_match_reg  <= locked_reg ^ lpol_reg;
      range_match_reg <= range_reg ^ rpol_reg;
      lock_irq  <= (locked_reg ^ lpol_reg) && !lock_match_reg;
      range_irq <= (range_reg ^ rpol_reg) && !range_match_reg;
    end
  end

  // Doze divider: CPU enable every 2^n peripheral cycles
  logic doze_tick;
  logic [3:0] doze_log2;
  assign doze_log2 = doze_enable_reg ? {1'b0, doze_reg} : 4'h0;
  ocr_divider #(.W(8)) u_doze (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .log2_div (doze_log2),
    .tick     (doze_tick)
  );

  // RC postscaler, code 111 jumps to 256
  logic rc_tick;
  logic [3:0] rc_log2;
  assign rc_log2 = (rcps_reg == 3'h7) ? 4'h8 : {1'b0, rcps_reg};
  ocr_divider #(.W(8)) u_rcps (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .log2_div (rc_log2),
    .tick     (rc_tick)
  );

  // Pin-facing outputs, all registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_osc_run   <= 1'b0;
      secondary_osc_run <= 1'b0;
      pll_run           <= 1'b0;
      source_sel_out    <= 3'h0;
      io_lock_out       <= 1'b0;
      cpu_clk_en        <= 1'b0;
      periph_clk_en     <= 1'b0;
      rc_clk_en         <= 1'b0;
      sys_postscale_out <= OCR_SYSPS_RST;
      selftune_active   <= 1'b0;
      selftune_ref_out  <= 1'b0;
      rc_trim_out       <= '0;
    end
    else
    begin
      primary_osc_run   <= !sleep_mode || psleep_reg;
      secondary_osc_run <= secondary_osc_reg;
      pll_run           <= pllon_reg || pll_mode;
      source_sel_out    <= csel_reg;
      io_lock_out       <= io_lock_reg;
      cpu_clk_en        <= doze_tick;
      periph_clk_en     <= 1'b1;
      rc_clk_en         <= rc_tick;
      sys_postscale_out <= sysps_reg;
      selftune_active   <= selftune_enable_reg && !(idlestop_reg && idle_mode);
      selftune_ref_out  <= refsel_reg;
      rc_trim_out       <= trim_reg;
    end
  end

  // AXI read channel
  logic [15:0] rd_word;
  logic        rd_known;
  always_comb
  begin
    rd_word  = '0;
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      OCR_OFS_OSC_CTRL:
        rd_word = {1'b0, csel_reg, 1'b0, nsel_reg, sel_lock_reg, io_lock_reg,
                   plock_reg, 1'b0, cfail_reg, psleep_reg, secondary_osc_reg,
                   swreq_reg};
      OCR_OFS_CLK_DIV:
        rd_word = {roi_reg, doze_reg, doze_enable_reg, rcps_reg, sysps_reg,
                   pllon_reg, 5'h00};
      OCR_OFS_RC_TUNE:
        rd_word = {selftune_enable_reg, 1'b0, idlestop_reg, refsel_reg, locked_reg,
                   lpol_reg, range_reg, rpol_reg, 2'h0, trim_reg};
      OCR_OFS_UNLOCK:
        rd_word = {15'h0000, unlocked_reg};
      default:
        rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= OCR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= rd_known ? OCR_RESP_OKAY : OCR_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ocr_osc_ctrl

// >>> logic/ocr_pkg.sv
// Register map, field positions and reset values for the oscillator control
package ocr_pkg;

  localparam logic [3:0]  OCR_OFS_OSC_CTRL  = 4'h0;
  localparam logic [3:0]  OCR_OFS_CLK_DIV   = 4'h4;
  localparam logic [3:0]  OCR_OFS_RC_TUNE   = 4'h8;
  localparam logic [3:0]  OCR_OFS_UNLOCK    = 4'hC;

  // Oscillator control fields
  localparam int OCR_SWREQ_BIT   = 0;
  localparam int OCR_SECONDARY_OSC_ENABLE_BIT  = 1;
  localparam int OCR_PSLEEP_BIT  = 2;
  localparam int OCR_CFAIL_BIT   = 3;
  localparam int OCR_PLOCK_BIT   = 5;
  localparam int OCR_IO_LOCK_A_BIT  = 6;
  localparam int OCR_SELLOCK_BIT = 7;
  localparam int OCR_NSEL_LSB    = 8;
  localparam int OCR_CSEL_LSB    = 12;

  // Clock divider fields
  localparam int OCR_PLLON_BIT   = 5;
  localparam int OCR_SYSPS_LSB   = 6;
  localparam int OCR_RCPS_LSB    = 8;
  localparam int OCR_DOZE_ENABLE_BIT   = 11;
  localparam int OCR_DOZE_LSB    = 12;
  localparam int OCR_ROI_BIT     = 15;

  // Tune control fields
  localparam int OCR_TRIM_LSB    = 0;
  localparam int OCR_RPOL_BIT    = 8;
  localparam int OCR_RANGE_BIT   = 9;
  localparam int OCR_LPOL_BIT    = 10;
  localparam int OCR_LOCKED_BIT  = 11;
  localparam int OCR_REFSEL_BIT  = 12;
  localparam int OCR_IDLESTOP_BIT = 13;
  localparam int OCR_SELFTUNE_ENABLE_BIT    = 15;

  localparam logic [2:0]  OCR_DOZE_RST   = 3'h3;
  localparam logic [2:0]  OCR_RCPS_RST   = 3'h1;
  localparam logic [1:0]  OCR_SYSPS_RST  = 2'h0;
  localparam logic [2:0]  OCR_SEL_PRI_PLL = 3'h3;
  localparam logic [2:0]  OCR_SEL_FRC_PLL = 3'h1;

  // Unlock key pair written to the unlock register
  localparam logic [7:0]  OCR_KEY1       = 8'h46;
  localparam logic [7:0]  OCR_KEY2       = 8'h57;

  localparam logic [1:0]  OCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  OCR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OCR_SW_IDLE, OCR_SW_WAIT, OCR_SW_DONE} ocr_sw_t;

endpackage

// >>> logic/ocr_divider.sv
// Power-of-two divider producing a one-cycle enable pulse
module ocr_divider
  import ocr_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [3:0]   log2_div,
  output logic              tick
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] mask;

  always_comb
  begin
    mask = W'((32'h1 << log2_div) - 32'h1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if ((cnt_reg & mask) == mask)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick <= 1'b0;
    else
      tick <= ((cnt_reg & mask) == mask);
  end

endmodule // ocr_divider

// >>> testbench/ocr_osc_ctrl_props.sv
// Port-level checks for the oscillator control block
module ocr_osc_ctrl_props
  import ocr_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        io_lock_one_way_cfg,
  input wire logic        io_lock_out,
  input wire logic        lock_irq,
  input wire logic        range_irq,
  input wire logic [2:0]  source_sel_out,
  input wire logic        pll_run,
  input wire logic        periph_clk_en,
  input wire logic [1:0]  sys_postscale_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_periph_always_on: assert property ($past(aresetn) |-> periph_clk_en)
    else $error("peripheral clock enable dropped");
  a_read_next_cycle: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_resp_two: assert property (s_axi_wvalid && s_axi_wready &&
    !(s_axi_awvalid && !s_axi_awready) |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after data");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_upper_read_zero: assert property
    (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_io_lock_oneway: assert property
    (io_lock_one_way_cfg && $past(aresetn) && $past(io_lock_out) |-> io_lock_out)
    else $error("one-way I/O lock cleared");
  a_lock_irq_pulse: assert property (lock_irq |=> !lock_irq)
    else $error("lock interrupt longer than one cycle");
  a_range_irq_pulse: assert property (range_irq |=> !range_irq)
    else $error("range interrupt longer than one cycle");
  a_pll_mode_on: assert property ((source_sel_out == OCR_SEL_FRC_PLL ||
    source_sel_out == OCR_SEL_PRI_PLL) [*3] |-> pll_run)
    else $error("PLL stopped in a PLL mode");
  a_sysps_reset: assert property
    ($rose(aresetn) |-> sys_postscale_out == OCR_SYSPS_RST)
    else $error("system postscale reset code wrong");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_lock_irq: cover property (lock_irq);
  c_range_irq: cover property (range_irq);
  c_switch: cover property ($changed(source_sel_out));
endmodule // ocr_osc_ctrl_props

bind ocr_osc_ctrl ocr_osc_ctrl_props u_props (.*);

// >>> testbench/ocr_osc_ctrl_tb_top.sv
// Directed register tests for the oscillator control block
module ocr_osc_ctrl_tb_top
  import ocr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [1:0] s_axi_bresp, s_axi_rresp, sys_postscale_out, rd_resp;
  logic monitor_switch_cfg, io_lock_one_way_cfg, pll_locked_in;
  logic clock_fail_in, switch_ready_in, irq_event, idle_mode, sleep_mode;
  logic tune_in_band, tune_beyond_range, tune_step, tune_up;
  logic primary_osc_run, secondary_osc_run, pll_run, io_lock_out;
  logic cpu_clk_en, periph_clk_en, rc_clk_en, selftune_active;
  logic selftune_ref_out, lock_irq, range_irq;
  logic [2:0] source_sel_out;
  logic [5:0] rc_trim_out;
  int err_count, n_tests, cyc;

  ocr_osc_ctrl dut (.*);

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Run needs about 1000 cycles; ceiling leaves margin
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // AW and W offered together; bready held until the answer
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask

  // Counts pulses on one output over n cycles to measure its rate
  task automatic pulses(input int sel, input int n,
                        input logic [31:0] exp);
    logic [31:0] c;
    c = '0;
    repeat (n)
    begin
      @(posedge aclk);
      case (sel)
        0: c = c + cpu_clk_en;
        1: c = c + rc_clk_en;
        2: c = c + lock_irq;
        default: c = c + range_irq;
      endcase
    end
    chk(c, exp);
  endtask

  task automatic unlock();
    wr(OCR_OFS_UNLOCK, {8'h00, OCR_KEY1});
    wr(OCR_OFS_UNLOCK, {8'h00, OCR_KEY2});
  endtask

  // Switch completion time depends on synchroniser lag
  task automatic wait_sel(input logic [2:0] s);
    for (int i = 0; i < 50 && source_sel_out !== s; i++)
      @(posedge aclk);
    chk({29'h0, source_sel_out}, {29'h0, s});
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
     s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {monitor_switch_cfg, clock_fail_in, irq_event, idle_mode, sleep_mode,
     tune_in_band, tune_beyond_range, tune_step, tune_up} = '0;
    {io_lock_one_way_cfg, pll_locked_in, switch_ready_in} = 3'h7;
    s_axi_wstrb = 4'h3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(OCR_OFS_CLK_DIV, 32'h0000_3100);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_7700);
    rdchk(OCR_OFS_RC_TUNE, 32'h0000_0000);
    pulses(1, 64, 32);
    pulses(0, 64, 64);
    rd(4'h2);
    chk({30'h0, rd_resp}, {30'h0, OCR_RESP_SLVERR});
    wr(OCR_OFS_OSC_CTRL, 16'h0042);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_7700);
    unlock();
    wr(OCR_OFS_OSC_CTRL, 16'h0103);
    wait_sel(3'h1);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_1122);
    chk({30'h0, secondary_osc_run, pll_run}, 32'h3);
    clock_fail_in <= 1'b1;
    repeat (4) @(posedge aclk);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_112A);
    clock_fail_in <= 1'b0;
    unlock();
    wr(OCR_OFS_OSC_CTRL, 16'h1142);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_1162);
    sleep_mode <= 1'b1;
    unlock();
    chk({31'h0, primary_osc_run}, 32'h0);
    wr(OCR_OFS_OSC_CTRL, 16'h1106);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_1166);
    chk({30'h0, io_lock_out, primary_osc_run}, 32'h3);
    monitor_switch_cfg <= 1'b1;
    unlock();
    wr(OCR_OFS_OSC_CTRL, 16'h1743);
    wait_sel(3'h7);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_7742);
    chk({31'h0, pll_run}, 32'h0);
    unlock();
    wr(OCR_OFS_OSC_CTRL, 16'h07C2);
    unlock();
    wr(OCR_OFS_OSC_CTRL, 16'h00C3);
    rdchk(OCR_OFS_OSC_CTRL, 32'h0000_77C2);
    monitor_switch_cfg <= 1'b0;
    unlock();
    wr(OCR_OFS_OSC_CTRL, 16'h00C3);
    wait_sel(3'h0);
    wr(OCR_OFS_CLK_DIV, 16'hB800);
    rdchk(OCR_OFS_CLK_DIV, 32'h0000_B800);
    pulses(0, 64, 8);
    irq_event <= 1'b1;
    @(posedge aclk);
    irq_event <= 1'b0;
    rdchk(OCR_OFS_CLK_DIV, 32'h0000_B000);
    pulses(0, 64, 64);
    wr(OCR_OFS_CLK_DIV, 16'h0FE0);
    rdchk(OCR_OFS_CLK_DIV, 32'h0000_0FE0);
    pulses(1, 512, 2);
    chk({29'h0, sys_postscale_out, pll_run}, 32'h7);
    wr(OCR_OFS_RC_TUNE, 16'h0005);
    wr(OCR_OFS_RC_TUNE, 16'h8005);
    wr(OCR_OFS_RC_TUNE, 16'h800A);
    tune_in_band <= 1'b1;
    pulses(2, 8, 1);
    tune_beyond_range <= 1'b1;
    tune_up <= 1'b1;
    tune_step <= 1'b1;
    pulses(3, 8, 1);
    rdchk(OCR_OFS_RC_TUNE, 32'h0000_8A05);
    chk({26'h0, rc_trim_out}, 32'h5);
    tune_beyond_range <= 1'b0;
    tune_step <= 1'b0;
    repeat (4) @(posedge aclk);
    tune_step <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({26'h0, rc_trim_out}, 32'h6);
    wr(OCR_OFS_RC_TUNE, 16'hB405);
    tune_in_band <= 1'b0;
    pulses(2, 8, 1);
    idle_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({30'h0, selftune_active, selftune_ref_out}, 32'h1);
    stop_test();
  end
endmodule // ocr_osc_ctrl_tb_top
